// ### msq_pkg.sv
// Shared constants, field codes and carriers for the microcode sequencer.
// Assumes it is compiled before every other sequencer file.
package msq_pkg;
  // Widths
  localparam int AW = 14;
  localparam int LUT_AW = 12;
  localparam int NIR_W = 16;
  localparam int NIR_LSB = 4;
  localparam int CNT_W = 8;
  localparam int NAME_W = 8;
  localparam int SRC_W = 3;
  localparam int FLG_W = 5;
  localparam int ADR_W = 5;
  // Address arithmetic
  localparam logic [AW-1:0] ADDR_ONE = 14'h0001;
  localparam logic [AW-1:0] PAIR_ADJ = 14'h0002;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  // Jump field codes
  localparam logic [2:0] J_NONE = 3'h0;
  localparam logic [2:0] J_FAST = 3'h1;
  localparam logic [2:0] J_MED = 3'h2;
  localparam logic [2:0] J_SLOW = 3'h3;
  localparam logic [2:0] J_RET1 = 3'h4;
  localparam logic [2:0] J_RET2 = 3'h5;
  // Skip field codes
  localparam logic [3:0] S_NONE = 4'h0;
  localparam logic [3:0] S_NEXT = 4'h1;
  localparam logic [3:0] S_SRZ = 4'h2;
  localparam logic [3:0] S_DATA = 4'h3;
  localparam logic [3:0] S_REPEAT_UNTIL_CONDITION = 4'h4;
  localparam logic [3:0] S_REPEAT_COUNTED = 4'h5;
  // Special field codes
  localparam logic [3:0] P_NONE = 4'h0;
  localparam logic [3:0] P_PUSH = 4'h1;
  localparam logic [3:0] P_POP = 4'h2;
  localparam logic [3:0] P_PREF = 4'h3;
  localparam logic [3:0] P_PREFR = 4'h4;
  localparam logic [3:0] P_IDX = 4'h5;
  // Register byte offsets
  localparam logic [ADR_W-1:0] R_FLAG = 5'h00;
  localparam logic [ADR_W-1:0] R_STAGE = 5'h04;
  localparam logic [ADR_W-1:0] R_LADR = 5'h08;
  localparam logic [ADR_W-1:0] R_LDAT = 5'h0c;
  localparam logic [ADR_W-1:0] R_STAT = 5'h10;
  localparam int PERR_BIT = 5;
  // One ALU half of a microword
  typedef struct packed {
    logic [5:0] cnt;
    logic store;
    logic [3:0] spec;
    logic [3:0] skip;
    logic [2:0] jmp;
    logic [AW-1:0] tgt;
  } msq_half_s;
  // Full microword, second ALU in the upper half
  typedef struct packed {
    msq_half_s b;
    msq_half_s a;
  } msq_word_s;
  // Lookup table word
  typedef struct packed {
    logic par;
    logic [3:0] ccm;
    logic bcc;
    logic ind;
    logic [1:0] idx;
    logic [1:0] base;
    logic [2:0] disp;
    logic sub;
    logic [SRC_W-1:0] srp;
    logic [AW-1:0] entry;
  } msq_lut_s;
  typedef enum logic [1:0] {RP_IDLE, RP_COND, RP_CNT} msq_rep_e;
endpackage : msq_pkg

// ### msq_opcode_lookup_table.sv
// Opcode lookup table: one opcode read port, one software port.
// Assumes writes come from the register slave on the same clock.
`timescale 1ns/1ps
module msq_opcode_lookup_table #(
  parameter int AWL = msq_pkg::LUT_AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [AWL-1:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [AWL-1:0] rd_addr_i,
  output msq_pkg::msq_lut_s entry_o,
  output logic [31:0] sw_data_o,
  output logic par_err_o
);
  logic [31:0] mem [2**AWL];
  logic [31:0] wdata;

  // Parity bit forces odd parity over the stored word
  assign wdata = {~^wr_data_i[30:0], wr_data_i[30:0]};
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[wr_addr_i] <= wdata;
    end
  end

  // Reads
  assign entry_o = msq_pkg::msq_lut_s'(mem[rd_addr_i]);
  assign sw_data_o = mem[wr_addr_i];
  assign par_err_o = ~^mem[rd_addr_i];

  AST_LUT_ODD: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && (wr_addr_i == rd_addr_i) ##1 $stable(rd_addr_i)
    |-> !par_err_o)
    else $error("stored table word lacks odd parity");
endmodule : msq_opcode_lookup_table

// ### msq_return_address_stack.sv
// Return address stack; pointer moves only on explicit push or pop.
// Assumes push, pop and writes arrive as one-cycle strobes.
`timescale 1ns/1ps
module msq_return_address_stack #(
  parameter int DEPTH = 8,
  parameter int AW = msq_pkg::AW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] wr_data_i,
  output logic [AW-1:0] top_o
);
  localparam int PW = $clog2(DEPTH);
  logic [AW-1:0] mem [DEPTH];
  logic [PW-1:0] ptr;

  // Pointer update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr <= '0;
    end else if (push_i && !pop_i) begin
      ptr <= ptr + PW'(1);
    end else if (pop_i && !push_i) begin
      ptr <= ptr - PW'(1);
    end
  end

  // Top entry write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_i) begin
      mem[ptr] <= wr_data_i;
    end
  end

  assign top_o = mem[ptr];

  AST_RAS_STILL: assert property (@(posedge clk_i) disable iff (rst_i)
    !push_i && !pop_i |=> $stable(ptr))
    else $error("stack pointer moved without push or pop");
endmodule : msq_return_address_stack

// ### msq_sequencer.sv
// Four-rank microcode sequencer with Wishbone register slave.
// Assumes a combinational-read microstore and datapath on clk_i.
`timescale 1ns/1ps
module msq_sequencer #(
  parameter logic [msq_pkg::AW-1:0] INT_VEC = 14'h0100,
  parameter logic [msq_pkg::AW-1:0] PREADJ_VEC = 14'h0200,
  parameter int RAS_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [msq_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [msq_pkg::AW-1:0] ms_addr_o,
  input wire logic [31:0] ms_lo_i,
  input wire logic [31:0] ms_hi_i,
  input wire logic [msq_pkg::NIR_W-1:0] nir_i,
  input wire logic nir_valid_i,
  input wire logic nir_paired_i,
  input wire logic intr_pending_i,
  input wire logic bounds_viol_i,
  input wire logic [1:0] skip_data_i,
  input wire logic [1:0] jump_data_i,
  input wire logic [1:0] cc_i,
  output logic [msq_pkg::NIR_W-1:0] cir_o,
  output logic [1:0] store_en_o,
  output logic operand_load_o,
  output logic alu_b_add_o,
  output logic alu_sub_o,
  output logic pc_inc_o,
  output logic prefetch_req_o,
  output logic prefetch_repeat_o,
  output logic index_add_o,
  output logic [1:0] base_sel_o,
  output logic [1:0] index_type_o,
  output logic [2:0] disp_width_o,
  output logic indirect_o,
  output logic frozen_o
);
  localparam int AW = msq_pkg::AW;
  localparam int CW = msq_pkg::CNT_W;

  // Pipeline state
  logic adv, hold, freeze, force_ovh, cmp2, ox, pre_need;
  logic [AW-1:0] microstore_addr_reg, pc1, pc2, pc3, bus, ret_addr, ras_top;
  msq_pkg::msq_word_s microstore_output_reg, w1, w2, w3, ovh_w;
  logic r1_nop, n1, r2_nop, r3_nop, r2_ovh, r3_ovh;
  logic [1:0] r2_srsk, r2_sup, r3_sup;
  logic kill0, kill1, jsb_wr, ras_push, ras_pop;
  msq_pkg::msq_half_s h1 [2];
  msq_pkg::msq_half_s h2 [2];
  msq_pkg::msq_half_s h3 [2];
  logic [1:0] j1, rt1, sk1, act2, j2, rt2, sk2, nx2, act3, j3;
  // Repeat state
  msq_pkg::msq_rep_e rp;
  logic rep_start, exit_c, exit_n;
  // Architectural state
  logic [msq_pkg::FLG_W-1:0] flags;
  logic flag_two, flag_five_b, lut_perr;
  logic [CW-1:0] main_cnt, aux_cnt;
  logic [msq_pkg::SRC_W-1:0] stack_reg, staged_ssc;
  logic [msq_pkg::NAME_W-1:0] name_reg, staged_name;
  msq_pkg::msq_lut_s opcode_lookup_table, lut_q;
  logic lut_perr_now;
  logic [31:0] lut_sw_data;
  logic [msq_pkg::LUT_AW-1:0] lut_addr;
  // Register slave
  logic ack, req, wr;

  // Winner of a rank: second ALU beats first
  function automatic logic [AW-1:0] msq_win(input logic [1:0] r,
      input msq_pkg::msq_half_s ha, input msq_pkg::msq_half_s hb);
    return r[1] ? hb.tgt : ha.tgt;
  endfunction : msq_win

  // Builds one of the four hardwired overhead lines
  function automatic msq_pkg::msq_word_s msq_ovh(input logic pre,
      input logic pair, input logic [AW-1:0] iv, input logic [AW-1:0] pv);
    msq_pkg::msq_word_s w;
    w = '0;
    if (pre) begin
      w.a.jmp = msq_pkg::J_FAST;
      w.a.tgt = pair ? pv - msq_pkg::PAIR_ADJ : pv;
    end else begin
      w.a.spec = msq_pkg::P_IDX;
      w.a.jmp = msq_pkg::J_SLOW;
      w.a.tgt = iv;
      w.b.spec = pair ? msq_pkg::P_PREFR : msq_pkg::P_PREF;
    end
    return w;
  endfunction : msq_ovh

  // Register address decode
  function automatic logic msq_hit(input logic [msq_pkg::ADR_W-1:0] a,
      input logic [msq_pkg::ADR_W-1:0] off);
    return a[msq_pkg::ADR_W-1:2] == off[msq_pkg::ADR_W-1:2];
  endfunction : msq_hit

  // Completion, freeze and overhead selection
  assign pre_need = stack_reg < opcode_lookup_table.srp;
  assign ovh_w = msq_ovh(pre_need, nir_paired_i, INT_VEC, PREADJ_VEC);
  assign cmp2 = |nx2;
  assign force_ovh = cmp2 | bounds_viol_i;
  assign freeze = cmp2 & ~nir_valid_i;
  assign adv = ~freeze;
  assign w1 = force_ovh ? ovh_w : microstore_output_reg;
  assign n1 = r1_nop & ~force_ovh;
  assign ox = adv & r2_ovh;

  // Per-ALU decode across ranks
  for (genvar a = 0; a < 2; a++) begin : g_alu
    assign h1[a] = (a == 1) ? w1.b : w1.a;
    assign h2[a] = (a == 1) ? w2.b : w2.a;
    assign h3[a] = (a == 1) ? w3.b : w3.a;
    assign j1[a] = ~n1 & (h1[a].jmp == msq_pkg::J_FAST);
    assign rt1[a] = ~n1 & (h1[a].jmp == msq_pkg::J_RET1);
    assign sk1[a] = ~n1 & (h1[a].skip == msq_pkg::S_SRZ)
                    & (stack_reg == '0);
    assign act2[a] = ~r2_nop & ~r2_sup[a];
    assign j2[a] = act2[a] & (h2[a].jmp == msq_pkg::J_MED);
    assign rt2[a] = act2[a] & (h2[a].jmp == msq_pkg::J_RET2);
    assign nx2[a] = act2[a] & (h2[a].skip == msq_pkg::S_NEXT);
    assign sk2[a] = act2[a] & (r2_srsk[a] | (skip_data_i[a]
                    & (h2[a].skip == msq_pkg::S_DATA)));
    assign act3[a] = ~r3_nop & ~r3_sup[a];
    assign j3[a] = act3[a] & (h3[a].jmp == msq_pkg::J_SLOW)
                   & (jump_data_i[a] | (r3_ovh & intr_pending_i));
    assign store_en_o[a] = adv & act2[a] & h2[a].store;
  end

  // Next microstore address with rank priority
  always_comb begin
    bus = microstore_addr_reg + msq_pkg::ADDR_ONE;
    kill0 = 1'b0;
    kill1 = 1'b0;
    jsb_wr = 1'b0;
    ret_addr = '0;
    if (|j3) begin
      bus = msq_win(j3, h3[0], h3[1]);
      kill0 = 1'b1;
      kill1 = 1'b1;
      jsb_wr = 1'b1;
      ret_addr = pc3 + msq_pkg::ADDR_ONE;
    end else if (|j2) begin
      bus = msq_win(j2, h2[0], h2[1]);
      kill0 = 1'b1;
      jsb_wr = 1'b1;
      ret_addr = pc2 + msq_pkg::ADDR_ONE;
    end else if (|rt2) begin
      bus = ras_top;
      kill0 = 1'b1;
    end else if (|j1) begin
      bus = msq_win(j1, h1[0], h1[1]);
      jsb_wr = 1'b1;
      ret_addr = pc1 + msq_pkg::ADDR_ONE;
    end else if (force_ovh) begin
      bus = opcode_lookup_table.entry;
    end else if (|rt1) begin
      bus = ras_top;
    end
  end

  // Repeat control
  assign rep_start = (rp == msq_pkg::RP_IDLE) & act2[0]
                     & ((h2[0].skip == msq_pkg::S_REPEAT_UNTIL_CONDITION)
                     | (h2[0].skip == msq_pkg::S_REPEAT_COUNTED));
  assign exit_c = (rp == msq_pkg::RP_COND) & (|sk2);
  assign exit_n = (rp == msq_pkg::RP_CNT) & (main_cnt == msq_pkg::CNT_ONE);
  assign hold = (rp == msq_pkg::RP_IDLE) ? rep_start : ~(exit_c | exit_n);
  assign alu_b_add_o = rep_start | (rp != msq_pkg::RP_IDLE);

  // Repeat state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rp <= msq_pkg::RP_IDLE;
    end else if (adv) begin
      case (rp)
        msq_pkg::RP_IDLE: begin
          if (rep_start && h2[0].skip == msq_pkg::S_REPEAT_UNTIL_CONDITION) begin
            rp <= msq_pkg::RP_COND;
          end else if (rep_start) begin
            rp <= msq_pkg::RP_CNT;
          end
        end
        msq_pkg::RP_COND: begin
          if (exit_c) begin
            rp <= msq_pkg::RP_IDLE;
          end
        end
        msq_pkg::RP_CNT: begin
          if (exit_n) begin
            rp <= msq_pkg::RP_IDLE;
          end
        end
        default: rp <= msq_pkg::RP_IDLE;
      endcase
    end
  end

  // Rank registers; rank 0 and 1 hold during repeat
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      microstore_addr_reg <= '0;
      pc1 <= '0;
      microstore_output_reg <= '0;
      r1_nop <= 1'b1;
      w2 <= '0;
      pc2 <= '0;
      r2_ovh <= 1'b0;
      r2_nop <= 1'b1;
      r2_srsk <= '0;
      r2_sup <= '0;
      w3 <= '0;
      pc3 <= '0;
      r3_ovh <= 1'b0;
      r3_nop <= 1'b1;
      r3_sup <= '0;
    end else if (adv) begin
      if (!hold) begin
        microstore_addr_reg <= bus;
        pc1 <= microstore_addr_reg;
        microstore_output_reg <= msq_pkg::msq_word_s'({ms_hi_i, ms_lo_i});
        r1_nop <= kill0;
      end
      w2 <= w1;
      pc2 <= pc1;
      r2_ovh <= force_ovh;
      r2_nop <= n1 | kill1;
      r2_srsk <= sk1;
      r2_sup <= exit_n ? 2'h0 : sk2;
      w3 <= w2;
      pc3 <= pc2;
      r3_ovh <= r2_ovh;
      r3_nop <= r2_nop;
      r3_sup <= r2_sup;
    end
  end
  assign ms_addr_o = microstore_addr_reg;
  assign operand_load_o = adv & ~n1;

  // Rank 2 specials
  assign ras_push = adv & |{act2[1] & (h2[1].spec == msq_pkg::P_PUSH),
                           act2[0] & (h2[0].spec == msq_pkg::P_PUSH)};
  assign ras_pop = adv & |{act2[1] & (h2[1].spec == msq_pkg::P_POP),
                          act2[0] & (h2[0].spec == msq_pkg::P_POP)};
  assign index_add_o = adv & act2[0] & (h2[0].spec == msq_pkg::P_IDX);
  assign pc_inc_o = adv & act2[1] & (h2[1].spec == msq_pkg::P_PREF);
  assign prefetch_repeat_o = adv & act2[1]
                             & (h2[1].spec == msq_pkg::P_PREFR);
  assign prefetch_req_o = pc_inc_o | prefetch_repeat_o;

  // Loop counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_cnt <= '0;
      aux_cnt <= '0;
    end else begin
      if (wr && msq_hit(wb_adr_i, msq_pkg::R_STAGE) && wb_sel_i[2]) begin
        aux_cnt <= wb_dat_i[23:16];
      end else if (ox) begin
        aux_cnt <= '0;
      end
      if (ox) begin
        main_cnt <= '0;
      end else if (adv && rep_start) begin
        main_cnt <= CW'(h2[0].cnt);
      end else if (adv && rp == msq_pkg::RP_CNT) begin
        main_cnt <= main_cnt - msq_pkg::CNT_ONE;
      end
    end
  end

  // Flags; a software set in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= '0;
      flag_two <= 1'b0;
      flag_five_b <= 1'b0;
    end else begin
      if (wr && msq_hit(wb_adr_i, msq_pkg::R_FLAG) && wb_sel_i[0]) begin
        flags <= (ox ? '0 : flags) | wb_dat_i[msq_pkg::FLG_W-1:0];
      end else if (ox) begin
        flags <= '0;
      end
      if (ox) begin
        flag_two <= lut_q.sub;
        flag_five_b <= lut_q.bcc & ~lut_q.ccm[cc_i];
      end
    end
  end
  assign alu_sub_o = flag_two;

  // Stack and name registers, staged copies
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_reg <= '0;
      name_reg <= '0;
      staged_ssc <= '0;
      staged_name <= '0;
    end else begin
      if (ox) begin
        stack_reg <= staged_ssc;
        name_reg <= staged_name;
      end
      if (wr && msq_hit(wb_adr_i, msq_pkg::R_STAGE)) begin
        if (wb_sel_i[0]) begin
          staged_ssc <= wb_dat_i[msq_pkg::SRC_W-1:0];
        end
        if (wb_sel_i[1]) begin
          staged_name <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Current instruction and table snapshot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cir_o <= '0;
      lut_q <= '0;
      lut_perr <= 1'b0;
    end else begin
      if (adv && cmp2 && !intr_pending_i && !pre_need) begin
        cir_o <= nir_i;
      end
      if (adv && force_ovh) begin
        lut_q <= opcode_lookup_table;
      end
      if (adv && force_ovh && lut_perr_now) begin
        lut_perr <= 1'b1;
      end else if (wr && msq_hit(wb_adr_i, msq_pkg::R_STAT)
                   && wb_sel_i[0] && wb_dat_i[msq_pkg::PERR_BIT]) begin
        lut_perr <= 1'b0;
      end
    end
  end
  assign base_sel_o = lut_q.base;
  assign index_type_o = lut_q.idx;
  assign disp_width_o = lut_q.disp;
  assign indirect_o = lut_q.ind;
  assign frozen_o = freeze;

  msq_opcode_lookup_table #(.AWL(msq_pkg::LUT_AW)) u_lut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr && msq_hit(wb_adr_i, msq_pkg::R_LDAT) && (&wb_sel_i)),
    .wr_addr_i(lut_addr),
    .wr_data_i(wb_dat_i),
    .rd_addr_i(nir_i[msq_pkg::NIR_W-1:msq_pkg::NIR_LSB]),
    .entry_o(opcode_lookup_table),
    .sw_data_o(lut_sw_data),
    .par_err_o(lut_perr_now)
  );

  msq_return_address_stack #(.DEPTH(RAS_DEPTH), .AW(AW)) u_ras (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(ras_push),
    .pop_i(ras_pop),
    .wr_i(adv && !hold && jsb_wr),
    .wr_data_i(ret_addr),
    .top_o(ras_top)
  );

  // Wishbone slave: one-cycle ack, registered read data
  // Writes land on the edge that the master sees ack high
  assign req = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack;
  assign wb_ack_o = ack;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= '0;
      lut_addr <= '0;
    end else begin
      ack <= req;
      if (wr && msq_hit(wb_adr_i, msq_pkg::R_LADR) && wb_sel_i[0]) begin
        lut_addr <= wb_dat_i[msq_pkg::LUT_AW-1:0];
      end
      if (req) begin
        if (msq_hit(wb_adr_i, msq_pkg::R_FLAG)) begin
          wb_dat_o <= {27'h0, flags};
        end else if (msq_hit(wb_adr_i, msq_pkg::R_STAGE)) begin
          wb_dat_o <= {8'h0, aux_cnt, staged_name, 5'h0, staged_ssc};
        end else if (msq_hit(wb_adr_i, msq_pkg::R_LADR)) begin
          wb_dat_o <= {20'h0, lut_addr};
        end else if (msq_hit(wb_adr_i, msq_pkg::R_LDAT)) begin
          wb_dat_o <= lut_sw_data;
        end else if (msq_hit(wb_adr_i, msq_pkg::R_STAT)) begin
          wb_dat_o <= {name_reg, aux_cnt, main_cnt, rp != msq_pkg::RP_IDLE,
                       freeze, lut_perr, flag_five_b, flag_two, stack_reg};
        end else begin
          wb_dat_o <= '0;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_OVH_FLAGS: assert property (ox && !wr |=> flags == '0)
    else $error("flags not cleared by overhead exit");
  AST_OVH_LOAD: assert property (ox |=> main_cnt == '0
    && stack_reg == $past(staged_ssc) && name_reg == $past(staged_name))
    else $error("counters or staged copies wrong after overhead");
  AST_FLAG_TWO: assert property (ox |=> alu_sub_o == $past(lut_q.sub))
    else $error("flag two not taken from table");
  AST_SEQ: assert property (adv && !hold && !(|{j3, j2, rt2, j1, rt1})
    && !force_ovh |=> ms_addr_o == $past(microstore_addr_reg) + msq_pkg::ADDR_ONE)
    else $error("sequential address not incremented");
  AST_R3_WIN: assert property (adv && !hold && (|j3)
    |=> ms_addr_o == $past(msq_win(j3, h3[0], h3[1])))
    else $error("rank three jump lost priority");
  AST_R3_NOP: assert property (adv && !hold && (|j3)
    |=> r1_nop && r2_nop)
    else $error("rank three jump did not insert two nops");
  AST_SKIP_SUP: assert property (adv && sk2[1] && !exit_n
    |=> r2_sup[1] && store_en_o[1] == 1'b0)
    else $error("skip did not suppress next microword");
  AST_JSB_RET: assert property (adv && !hold && jsb_wr
    && !ras_push && !ras_pop |=> ras_top == $past(ret_addr))
    else $error("return address not written on top");
  AST_FREEZE: assert property (freeze |=> $stable(ms_addr_o)
    && $stable(cir_o))
    else $error("sequencer moved while frozen");
  AST_CIR_BLOCK: assert property (cmp2 && intr_pending_i
    |=> $stable(cir_o))
    else $error("instruction moved with interrupt pending");

  COV_R3_JUMP: cover property (adv && (|j3));
  COV_REPEAT: cover property (adv && rep_start ##1 hold);
  COV_FREEZE: cover property (freeze ##1 !freeze);
  COV_OVH_EXIT: cover property (ox);
endmodule : msq_sequencer

// ### msq_microstore_model.sv
// Writable microstore model on the far side of the sequencer.
// Assumes the bench loads words through the write port, both during reset and while the sequencer runs.
`timescale 1ns/1ps
module msq_microstore_model (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [msq_pkg::AW-1:0] wr_addr_i,
  input wire msq_pkg::msq_word_s wr_data_i,
  input wire logic [msq_pkg::AW-1:0] addr_i,
  output logic [31:0] lo_o,
  output logic [31:0] hi_o
);
  msq_pkg::msq_word_s mem [0:(1<<msq_pkg::AW)-1] = '{default: '0};
  // Store loads
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
  // Two 32-bit sections, combinational read
  assign lo_o = mem[addr_i].a;
  assign hi_o = mem[addr_i].b;
endmodule : msq_microstore_model

// ### msq_sequencer_bench.sv
// Self-checking bench: register bus, table parity, address sequencing.
// Assumes msq_pkg and the microstore model are compiled first.
`timescale 1ns/1ps
module msq_sequencer_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, wb_dat_o, lo, hi, q, d;
  logic wb_ack_o, mwr = 1'b0, frz, nv = 1'b1, ip = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [15:0] prefetched_instr_reg = 16'h0030, current_instr_reg;
  localparam logic [13:0] IV = 14'h0100;
  localparam logic [13:0] ENT = 14'h0123;
  logic [13:0] ms_addr, mwa = 14'h0;
  msq_pkg::msq_word_s mwd = '0;
  int fail_count = 0, total_checks = 0, ea;
  always #5 clk_i = ~clk_i;
  msq_microstore_model ms (.clk_i(clk_i), .wr_i(mwr), .wr_addr_i(mwa),
    .wr_data_i(mwd), .addr_i(ms_addr), .lo_o(lo), .hi_o(hi));
  msq_sequencer #(.INT_VEC(IV)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ms_addr_o(ms_addr), .ms_lo_i(lo), .ms_hi_i(hi),
    .nir_i(prefetched_instr_reg), .nir_valid_i(nv), .nir_paired_i(1'b0),
    .intr_pending_i(ip), .bounds_viol_i(1'b0), .skip_data_i(2'h0),
    .jump_data_i(2'h0), .cc_i(2'h0), .cir_o(current_instr_reg), .store_en_o(),
    .operand_load_o(), .alu_b_add_o(), .alu_sub_o(), .pc_inc_o(),
    .prefetch_req_o(), .prefetch_repeat_o(), .index_add_o(),
    .base_sel_o(), .index_type_o(), .disp_width_o(), .indirect_o(),
    .frozen_o(frz));
  // Compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Verdict
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // Classic Wishbone single cycle
  task wb(input logic w, input logic [4:0] a, input logic [31:0] v);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk_i);
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
  endtask : wb
  // Completion word three lines ahead, freeze, then overhead exit
  task nxt(input logic i);
    msq_pkg::msq_word_s w;
    w = '0;
    w.a.skip = msq_pkg::S_NEXT;
    ea = ms_addr;
    mwd <= w;
    mwa <= ms_addr + 14'h3;
    mwr <= 1'b1;
    nv <= 1'b0;
    ip <= i;
    @(posedge clk_i);
    mwr <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("frozen", frz, 1);
    chk("held addr", ms_addr, ea + 5);
    nv <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("entry", ms_addr, ENT);
    @(posedge clk_i);
    chk("entry next", ms_addr, ENT + 14'h1);
    @(posedge clk_i);
    chk("intr jump", ms_addr, i ? IV : ENT + 14'h2);
  endtask : nxt
  initial begin
    void'($urandom(53));
    // Fast jump in the first half of word 5
    mwd.a.jmp = msq_pkg::J_FAST;
    mwd.a.tgt = 14'h0040;
    mwa <= 14'h0005;
    mwr <= 1'b1;
    repeat (6) @(posedge clk_i);
    mwr <= 1'b0;
    rst_i <= 1'b0;
    #1 chk("reset addr", ms_addr, 0);
    // Sequencing with a rank-1 jump and its delay slot
    ea = ms_addr;
    repeat (12) begin
      @(posedge clk_i);
      #1 ea = (ea == 6) ? 'h40 : ea + 1;
      chk("ms_addr", ms_addr, ea);
    end
    $display("test sequencing done");
    // Table word parity, random payload
    @(posedge clk_i);
    d = $urandom;
    wb(1'b1, msq_pkg::R_LADR, 32'h3);
    wb(1'b1, msq_pkg::R_LDAT, d);
    wb(1'b0, msq_pkg::R_LDAT, 0);
    chk("lut word", q, {~^d[30:0], d[30:0]});
    wb(1'b0, 5'h14, 0);
    chk("unmapped", q, 0);
    $display("test registers done");
    // Table word: entry, subtract, branch not taken for any code
    wb(1'b1, msq_pkg::R_LDAT, {18'h01008, ENT});
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, msq_pkg::R_FLAG, 32'h1f);
      wb(1'b1, msq_pkg::R_STAGE, 32'h00335a05);
      nxt(k == 0);
      wb(1'b0, msq_pkg::R_FLAG, 0);
      chk("flags", q, 0);
      wb(1'b0, msq_pkg::R_STAT, 0);
      chk("status", q, 32'h5a00001d);
      chk("cir", current_instr_reg, (k == 0) ? 0 : prefetched_instr_reg);
    end
    $display("test completion done");
    wrap_up();
  end
endmodule : msq_sequencer_bench
